//--- src/uri_defs.vh
/*
 * Constants of the serial port register block: register indices, field
 * positions, reset values, interrupt layout and baud timing figures.
 * Assumes a single 20 MHz system clock and 32-bit Avalon-MM word access.
 */
`ifndef URI_DEFS_VH
`define URI_DEFS_VH

// Register indices; the byte address is four times the index.
`define URI_CTRL_IDX 16'hc0e0
`define URI_STAT_IDX 16'hc0e2
`define URI_DATA_IDX 16'hc0e4
`define URI_IRQ_STAT_IDX 16'hc100
`define URI_IRQ_EN_IDX 16'hc102
`define URI_IRQ_CLR_IDX 16'hc104

// Control fields and reset value.
`define URI_CTRL_ENABLE_BIT 0
`define URI_CTRL_BAUD_LSB 1
`define URI_CTRL_BAUD_MSB 3
`define URI_CTRL_BAUD_DIVIDE_BY_EIGHT_BIT 4
`define URI_CTRL_RESET 5'h07

// Status fields.
`define URI_STAT_TX_FULL_BIT 0
`define URI_STAT_RX_FULL_BIT 1

// Interrupt status layout.
`define URI_IRQ_TX_DONE_BIT 0
`define URI_IRQ_RX_GOT_BIT 1
`define URI_IRQ_FRAME_ERR_BIT 2

// Clock figures: system period and reference rate in MHz.
`define URI_CLK_PERIOD_NS 50
`define URI_CLK_MHZ (1000 / `URI_CLK_PERIOD_NS)
`define URI_REF_MHZ 48
`define URI_PRESCALE 8
`define URI_OVERSAMPLE 16

// Reference-clock ticks per sixteenth of a bit for each baud code.
`define URI_DIV_115K2 26
`define URI_DIV_57K6 52
`define URI_DIV_38K4 78
`define URI_DIV_28K8 104
`define URI_DIV_19K2 156
`define URI_DIV_14K4 208
`define URI_DIV_9K6 312
`define URI_DIV_7K2 417

`endif

//--- src/uri_top.v
/*
 * Serial port with control, status and data registers behind an Avalon-MM
 * slave with waitrequest, a transmitter, a receiver and interrupt logic.
 * Assumes the master holds its request until waitrequest is seen low, and
 * that the receive pin is asynchronous to i_clock.
 */
// The Avalon-MM interface to the registers was chosen for this implementation.
`timescale 1ns/1ns
`include "uri_defs.vh"

module uri_top (
    input wire i_clock,                  // 20 MHz system clock.
    input wire i_reset_n,                // Asynchronous reset, active low.
    input wire [17:0] i_address,         // Avalon byte address.
    input wire i_read,                   // Avalon read request.
    input wire i_write,                  // Avalon write request.
    input wire [31:0] i_writedata,       // Avalon write data.
    input wire [3:0] i_byteenable,       // Avalon byte enables.
    output reg [31:0] o_readdata,        // Avalon read data.
    output reg o_waitrequest,            // Avalon waitrequest.
    output reg o_irq,                    // Level interrupt from sticky status.
    input wire i_int_enable_serial,      // Serial-port bit of the CPU interrupt enable.
    output reg o_cpu_int4,               // Transmit-empty CPU interrupt.
    output reg o_cpu_int5,               // Receive-full CPU interrupt.
    output reg o_shared_pin_transmit,    // Serial transmit pin level.
    output reg o_shared_pin_transmit_oe, // High while the port drives the pin.
    input wire i_shared_pin_receive      // Serial receive pin.
);

    localparam RX_IDLE = 2'd0;
    localparam RX_START = 2'd1;
    localparam RX_DATA = 2'd2;
    localparam RX_STOP = 2'd3;
    localparam [17:0] ADDR_CTRL = {`URI_CTRL_IDX, 2'b00};
    localparam [17:0] ADDR_STAT = {`URI_STAT_IDX, 2'b00};
    localparam [17:0] ADDR_DATA = {`URI_DATA_IDX, 2'b00};
    localparam [17:0] ADDR_IRQ_STAT = {`URI_IRQ_STAT_IDX, 2'b00};
    localparam [17:0] ADDR_IRQ_EN = {`URI_IRQ_EN_IDX, 2'b00};
    localparam [17:0] ADDR_IRQ_CLR = {`URI_IRQ_CLR_IDX, 2'b00};
    localparam [16:0] REF_STEP = `URI_REF_MHZ;
    localparam [16:0] CLK_WEIGHT = `URI_CLK_MHZ;
    localparam [16:0] PRESCALE = `URI_PRESCALE;
    localparam [16:0] DIV_115K2 = `URI_DIV_115K2;
    localparam [16:0] DIV_57K6 = `URI_DIV_57K6;
    localparam [16:0] DIV_38K4 = `URI_DIV_38K4;
    localparam [16:0] DIV_28K8 = `URI_DIV_28K8;
    localparam [16:0] DIV_19K2 = `URI_DIV_19K2;
    localparam [16:0] DIV_14K4 = `URI_DIV_14K4;
    localparam [16:0] DIV_9K6 = `URI_DIV_9K6;
    localparam [16:0] DIV_7K2 = `URI_DIV_7K2;

    reg wait_reg;
    reg [4:0] ctrl_reg;
    reg tx_full_reg;
    reg rx_full_reg;
    reg [7:0] tx_data_reg;
    reg [7:0] rx_data_reg;
    reg [2:0] irq_stat_reg;
    reg [2:0] irq_stat_next;
    reg [2:0] irq_en_reg;
    reg [16:0] acc_reg;
    reg [16:0] acc_sum;
    reg [16:0] div_sel;
    reg [16:0] thr;
    reg tick_reg;
    reg rx_s1_reg;
    reg rx_s2_reg;
    reg rx_s3_reg;
    reg rx_level_reg;
    reg tx_busy_reg;
    reg [9:0] tx_shift_reg;
    reg [3:0] tx_bit_reg;
    reg [3:0] tx_tick_reg;
    reg [1:0] rx_state_reg;
    reg [3:0] rx_tick_reg;
    reg [2:0] rx_bit_reg;
    reg [7:0] rx_shift_reg;

    wire enable = ctrl_reg[`URI_CTRL_ENABLE_BIT];
    wire req = i_read | i_write;
    wire accept = req & ~wait_reg;
    wire wr_ok = accept & i_write & i_byteenable[0];
    wire rd_data = accept & i_read & (i_address == ADDR_DATA);
    wire tx_done = tx_busy_reg & tick_reg & (tx_tick_reg == 4'hf) & (tx_bit_reg == 4'd9);
    wire rx_end = (rx_state_reg == RX_STOP) & tick_reg & (rx_tick_reg == 4'hf);
    wire rx_got = rx_end & rx_level_reg;
    wire rx_bad = rx_end & ~rx_level_reg;

    // Waitrequest drops for one cycle per request; the access acts at that edge.
    always @(posedge i_clock or negedge i_reset_n) begin
        if (!i_reset_n) begin
            wait_reg <= 1'b1;
            o_waitrequest <= 1'b1;
        end else begin
            wait_reg <= ~(req & wait_reg);
            o_waitrequest <= ~(req & wait_reg);
        end
    end

    // Read data is captured one cycle ahead so it stands when waitrequest is low.
    always @(posedge i_clock or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_readdata <= 32'h0;
        end else if (i_read & wait_reg) begin
            case (i_address)
                ADDR_CTRL: o_readdata <= {27'h0, ctrl_reg};
                ADDR_STAT: o_readdata <= {30'h0, rx_full_reg, tx_full_reg};
                ADDR_DATA: o_readdata <= {24'h0, rx_data_reg};
                ADDR_IRQ_STAT: o_readdata <= {29'h0, irq_stat_reg};
                ADDR_IRQ_EN: o_readdata <= {29'h0, irq_en_reg};
                default: o_readdata <= 32'h0;
            endcase
        end
    end

    // Control and interrupt-enable writes; reserved bits are simply not stored.
    always @(posedge i_clock or negedge i_reset_n) begin
        if (!i_reset_n) begin
            ctrl_reg <= `URI_CTRL_RESET;
            irq_en_reg <= 3'h0;
        end else if (wr_ok) begin
            if (i_address == ADDR_CTRL) begin
                ctrl_reg <= i_writedata[4:0];
            end
            if (i_address == ADDR_IRQ_EN) begin
                irq_en_reg <= i_writedata[2:0];
            end
        end
    end

    // Buffer flags. The status address has no write path at all.
    always @(posedge i_clock or negedge i_reset_n) begin
        if (!i_reset_n) begin
            tx_full_reg <= 1'b0;
            rx_full_reg <= 1'b0;
            tx_data_reg <= 8'h0;
            rx_data_reg <= 8'h0;
        end else begin
            if (wr_ok && i_address == ADDR_DATA) begin
                tx_data_reg <= i_writedata[7:0];
                tx_full_reg <= 1'b1;
            end else if (tx_done) begin
                tx_full_reg <= 1'b0;
            end
            // A byte landing in the same cycle as the read keeps the flag set.
            if (rx_got) begin
                rx_data_reg <= rx_shift_reg;
                rx_full_reg <= 1'b1;
            end else if (rd_data) begin
                rx_full_reg <= 1'b0;
            end
        end
    end

    // Sticky interrupt bits; a new event beats a clear in the same cycle.
    always @* begin
        irq_stat_next = irq_stat_reg;
        if (wr_ok && i_address == ADDR_IRQ_CLR) begin
            irq_stat_next = irq_stat_reg & ~i_writedata[2:0];
        end
        irq_stat_next = irq_stat_next | {rx_bad, rx_got, tx_done};
    end

    // Interrupt outputs, all registered.
    always @(posedge i_clock or negedge i_reset_n) begin
        if (!i_reset_n) begin
            irq_stat_reg <= 3'h0;
            o_irq <= 1'b0;
            o_cpu_int4 <= 1'b0;
            o_cpu_int5 <= 1'b0;
        end else begin
            irq_stat_reg <= irq_stat_next;
            o_irq <= |(irq_stat_next & irq_en_reg);
            o_cpu_int4 <= i_int_enable_serial & enable & ~tx_full_reg;
            o_cpu_int5 <= i_int_enable_serial & rx_full_reg;
        end
    end

    // Baud code to reference ticks per sixteenth bit.
    always @* begin
        case (ctrl_reg[`URI_CTRL_BAUD_MSB:`URI_CTRL_BAUD_LSB])
            3'd0: div_sel = DIV_115K2;
            3'd1: div_sel = DIV_57K6;
            3'd2: div_sel = DIV_38K4;
            3'd3: div_sel = DIV_28K8;
            3'd4: div_sel = DIV_19K2;
            3'd5: div_sel = DIV_14K4;
            3'd6: div_sel = DIV_9K6;
            default: div_sel = DIV_7K2;
        endcase
        // The prescaler stretches every sixteenth by eight; the product fits 17 bits.
        if (ctrl_reg[`URI_CTRL_BAUD_DIVIDE_BY_EIGHT_BIT]) begin
            thr = div_sel * CLK_WEIGHT * PRESCALE;
        end else begin
            thr = div_sel * CLK_WEIGHT;
        end
        acc_sum = acc_reg + REF_STEP;
    end

    // Each system cycle stands for 2.4 reference ticks; the accumulator
    // carries the fraction so the long-run rate matches the 48 MHz division.
    always @(posedge i_clock or negedge i_reset_n) begin
        if (!i_reset_n) begin
            acc_reg <= 17'h0;
            tick_reg <= 1'b0;
        end else if (!enable) begin
            acc_reg <= 17'h0;
            tick_reg <= 1'b0;
        end else if (acc_sum >= thr) begin
            acc_reg <= acc_sum - thr;
            tick_reg <= 1'b1;
        end else begin
            acc_reg <= acc_sum;
            tick_reg <= 1'b0;
        end
    end

    // Receive pin synchroniser; a level counts once stages two and three agree.
    always @(posedge i_clock or negedge i_reset_n) begin
        if (!i_reset_n) begin
            rx_s1_reg <= 1'b1;
            rx_s2_reg <= 1'b1;
            rx_s3_reg <= 1'b1;
            rx_level_reg <= 1'b1;
        end else begin
            rx_s1_reg <= i_shared_pin_receive;
            rx_s2_reg <= rx_s1_reg;
            rx_s3_reg <= rx_s2_reg;
            if (rx_s2_reg == rx_s3_reg) begin
                rx_level_reg <= rx_s3_reg;
            end
        end
    end

    // Transmitter: start, eight data bits LSB first, stop, sixteen ticks each.
    always @(posedge i_clock or negedge i_reset_n) begin
        if (!i_reset_n) begin
            tx_busy_reg <= 1'b0;
            tx_shift_reg <= 10'h3ff;
            tx_bit_reg <= 4'h0;
            tx_tick_reg <= 4'h0;
        end else if (!enable) begin
            tx_busy_reg <= 1'b0;
            tx_shift_reg <= 10'h3ff;
            tx_bit_reg <= 4'h0;
            tx_tick_reg <= 4'h0;
        end else if (!tx_busy_reg) begin
            if (tx_full_reg) begin
                tx_busy_reg <= 1'b1;
                tx_shift_reg <= {1'b1, tx_data_reg, 1'b0};
                tx_bit_reg <= 4'h0;
                tx_tick_reg <= 4'h0;
            end
        end else if (tick_reg) begin
            tx_tick_reg <= tx_tick_reg + 4'h1;
            if (tx_tick_reg == 4'hf) begin
                tx_shift_reg <= {1'b1, tx_shift_reg[9:1]};
                tx_bit_reg <= tx_bit_reg + 4'h1;
                if (tx_bit_reg == 4'd9) begin
                    tx_busy_reg <= 1'b0;
                end
            end
        end
    end

    // Pin drive; disabling the port hands the pin back by dropping the enable.
    always @(posedge i_clock or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_shared_pin_transmit <= 1'b1;
            o_shared_pin_transmit_oe <= 1'b0;
        end else begin
            o_shared_pin_transmit <= tx_busy_reg ? tx_shift_reg[0] : 1'b1;
            o_shared_pin_transmit_oe <= enable;
        end
    end

    // Receiver: confirm start at mid-bit, then sample every sixteen ticks.
    always @(posedge i_clock or negedge i_reset_n) begin
        if (!i_reset_n) begin
            rx_state_reg <= RX_IDLE;
            rx_tick_reg <= 4'h0;
            rx_bit_reg <= 3'h0;
            rx_shift_reg <= 8'h0;
        end else if (!enable) begin
            rx_state_reg <= RX_IDLE;
            rx_tick_reg <= 4'h0;
            rx_bit_reg <= 3'h0;
        end else begin
            case (rx_state_reg)
                RX_IDLE: begin
                    rx_tick_reg <= 4'h0;
                    if (!rx_level_reg) begin
                        rx_state_reg <= RX_START;
                    end
                end
                RX_START: begin
                    if (tick_reg) begin
                        rx_tick_reg <= rx_tick_reg + 4'h1;
                        if (rx_tick_reg == 4'h7) begin
                            // A glitch shorter than half a bit is dropped here.
                            rx_tick_reg <= 4'h0;
                            rx_bit_reg <= 3'h0;
                            rx_state_reg <= rx_level_reg ? RX_IDLE : RX_DATA;
                        end
                    end
                end
                RX_DATA: begin
                    if (tick_reg) begin
                        rx_tick_reg <= rx_tick_reg + 4'h1;
                        if (rx_tick_reg == 4'hf) begin
                            rx_shift_reg <= {rx_level_reg, rx_shift_reg[7:1]};
                            rx_bit_reg <= rx_bit_reg + 3'h1;
                            if (rx_bit_reg == 3'h7) begin
                                rx_state_reg <= RX_STOP;
                            end
                        end
                    end
                end
                RX_STOP: begin
                    if (tick_reg) begin
                        rx_tick_reg <= rx_tick_reg + 4'h1;
                        if (rx_tick_reg == 4'hf) begin
                            rx_state_reg <= RX_IDLE;
                        end
                    end
                end
                default: rx_state_reg <= RX_IDLE;
            endcase
        end
    end

endmodule // uri_top

//--- tb/test_uart_register_interface.sv
/*
 * Self-checking bench for the serial port registers, transmitter and receiver.
 * Assumes a 20 MHz clock and the serial partner model on the pins.
 */
`timescale 1ns/1ns
`include "uri_defs.vh"
module test_uart_register_interface;
    localparam [17:0] A_CTRL = {`URI_CTRL_IDX, 2'b00};
    localparam [17:0] A_STAT = {`URI_STAT_IDX, 2'b00};
    localparam [17:0] A_DATA = {`URI_DATA_IDX, 2'b00};
    localparam [17:0] A_IEN = {`URI_IRQ_EN_IDX, 2'b00};
    localparam [17:0] A_ICLR = {`URI_IRQ_CLR_IDX, 2'b00};
    localparam [17:0] A_ISTAT = {`URI_IRQ_STAT_IDX, 2'b00};
    localparam int P_OE = 0;
    localparam int P_INT4 = 1;
    localparam int P_INT5 = 2;
    localparam int P_IRQ = 3;
    logic i_clock = 1'b0;
    logic i_reset_n = 1'b0;
    logic [17:0] i_address = 18'h0;
    logic i_read = 1'b0;
    logic i_write = 1'b0;
    logic [31:0] i_writedata = 32'h0;
    logic [3:0] i_byteenable = 4'h1;
    logic i_int_enable_serial = 1'b1;
    wire [31:0] o_readdata;
    wire o_waitrequest;
    wire o_irq;
    wire o_cpu_int4;
    wire o_cpu_int5;
    wire o_txd;
    wire o_txd_oe;
    wire rxd;
    // Outputs watched by the pin task, read after its wait rather than at the call.
    wire [3:0] outs = {o_irq, o_cpu_int5, o_cpu_int4, o_txd_oe};
    int err_count = 0;
    int cmp_count = 0;
    logic [31:0] q;
    // Control word, its rate and a test byte; the first uses the prescaler.
    logic [31:0] ctrl [4] = '{32'h11, 32'h07, 32'h0d, 32'h01};
    real baud [4] = '{14400.0, 28800.0, 9600.0, 115200.0};
    logic [7:0] tx_byte [4] = '{8'h5a, 8'hc3, 8'h81, 8'h3e};
    always #25 i_clock = ~i_clock;
    uri_top i_uri_top (.i_clock(i_clock), .i_reset_n(i_reset_n), .i_address(i_address),
        .i_read(i_read), .i_write(i_write), .i_writedata(i_writedata),
        .i_byteenable(i_byteenable), .o_readdata(o_readdata), .o_waitrequest(o_waitrequest),
        .o_irq(o_irq), .i_int_enable_serial(i_int_enable_serial), .o_cpu_int4(o_cpu_int4),
        .o_cpu_int5(o_cpu_int5), .o_shared_pin_transmit(o_txd),
        .o_shared_pin_transmit_oe(o_txd_oe), .i_shared_pin_receive(rxd));
    uri_partner i_uri_partner (.i_line_in(o_txd), .i_line_oe(o_txd_oe), .o_line_out(rxd));
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            err_count++;
            $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    // One Avalon access, held until waitrequest is sampled low.
    task automatic bus(input logic wr, input logic [17:0] a, input logic [31:0] d);
        @(posedge i_clock);
        i_address <= a;
        i_read <= !wr;
        i_write <= wr;
        i_writedata <= d;
        do @(posedge i_clock); while (o_waitrequest !== 1'b0);
        q = o_readdata;
        i_read <= 1'b0;
        i_write <= 1'b0;
    endtask
    task automatic rd_chk(input logic [17:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        chk(q, exp);
    endtask
    // Reads until the masked bits match; the watchdog ends a hang.
    task automatic poll(input logic [17:0] a, input logic [31:0] m, input logic [31:0] v);
        do bus(1'b0, a, 32'h0); while ((q & m) !== v);
        chk(q & m, v);
    endtask
    // Lets the registered output settle, then samples the selected one on the edge.
    task automatic pin(input int sel, input logic exp);
        repeat (3) @(posedge i_clock);
        chk({31'h0, outs[sel]}, {31'h0, exp});
    endtask
    task automatic results;
        if (err_count == 0 && cmp_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    initial begin
        repeat (100000) @(posedge i_clock);
        err_count++;
        results();
    end
    initial begin
        repeat (12) @(posedge i_clock);
        i_reset_n <= 1'b1;
        rd_chk(A_CTRL, 32'h7);
        rd_chk(A_STAT, 32'h0);
        rd_chk(18'h3fffc, 32'h0);
        bus(1'b1, A_CTRL, 32'h0);
        pin(P_OE, 1'b0);
        bus(1'b1, A_STAT, 32'h3);
        rd_chk(A_STAT, 32'h0);
        // Each rate is judged by the partner decoding at the expected bit time.
        for (int i = 0; i < 4; i++) begin
            bus(1'b1, A_CTRL, ctrl[i]);
            i_uri_partner.bit_ns = 1.0e9 / baud[i];
            bus(1'b1, A_DATA, {24'h0, tx_byte[i]});
            rd_chk(A_STAT, 32'h1);
            poll(A_STAT, 32'h1, 32'h0);
            chk({24'h0, i_uri_partner.got}, {24'h0, tx_byte[i]});
            chk({31'h0, i_uri_partner.stop_ok}, 32'h1);
            pin(P_INT4, 1'b1);
        end
        // Every finished character has left its sticky done bit behind.
        rd_chk(A_ISTAT, 32'h1);
        i_int_enable_serial <= 1'b0;
        pin(P_INT4, 1'b0);
        i_int_enable_serial <= 1'b1;
        bus(1'b1, A_ICLR, 32'h7);
        bus(1'b1, A_IEN, 32'h2);
        i_uri_partner.send(8'h96);
        poll(A_STAT, 32'h2, 32'h2);
        pin(P_INT5, 1'b1);
        pin(P_IRQ, 1'b1);
        rd_chk(A_ISTAT, 32'h2);
        bus(1'b1, A_IEN, 32'h0);
        pin(P_IRQ, 1'b0);
        bus(1'b1, A_IEN, 32'h2);
        pin(P_IRQ, 1'b1);
        rd_chk(A_DATA, 32'h96);
        rd_chk(A_STAT, 32'h0);
        pin(P_INT5, 1'b0);
        bus(1'b1, A_ICLR, 32'h2);
        pin(P_IRQ, 1'b0);
        rd_chk(A_ISTAT, 32'h0);
        results();
    end
endmodule // test_uart_register_interface

//--- tb/uri_assertions.sv
/*
 * Checker for the serial port register block, seeing only its top ports.
 * Assumes the 20 MHz clock and the active-low asynchronous reset of the top.
 */
`timescale 1ns/1ns
`include "uri_defs.vh"
module uri_checker (
    input wire i_clock,                  // Clock.
    input wire i_reset_n,                // Reset, active low.
    input wire [17:0] i_address,         // Byte address.
    input wire i_read,                   // Read request.
    input wire i_write,                  // Write request.
    input wire [31:0] i_writedata,       // Write data.
    input wire [3:0] i_byteenable,       // Byte enables.
    input wire [31:0] o_readdata,        // Read data.
    input wire o_waitrequest,            // Wait request.
    input wire o_irq,                    // Level interrupt.
    input wire i_int_enable_serial,      // CPU enable bit.
    input wire o_cpu_int4,               // Transmit-empty interrupt.
    input wire o_cpu_int5,               // Receive-full interrupt.
    input wire o_shared_pin_transmit,    // Transmit pin.
    input wire o_shared_pin_transmit_oe, // Transmit enable.
    input wire i_shared_pin_receive      // Receive pin.
);
    localparam [17:0] A_CTRL = {`URI_CTRL_IDX, 2'b00};
    localparam [17:0] A_STAT = {`URI_STAT_IDX, 2'b00};
    localparam [17:0] A_DATA = {`URI_DATA_IDX, 2'b00};
    default clocking @(posedge i_clock); endclocking
    default disable iff (!i_reset_n);
    // Accepted accesses; a write without lane 0 is ignored by the block.
    wire wr_ok = i_write && !o_waitrequest && i_byteenable[0];
    wire rd_ok = i_read && !o_waitrequest;
    chk_wait_once: assert property (
        (i_read || i_write) && o_waitrequest |=> !o_waitrequest) else $error("no answer");
    chk_wait_single: assert property (
        !o_waitrequest |=> o_waitrequest) else $error("answer too long");
    chk_port_off: assert property (
        wr_ok && i_address == A_CTRL && !i_writedata[0] |-> ##[1:3] !o_shared_pin_transmit_oe)
        else $error("pin kept");
    chk_port_on: assert property (
        wr_ok && i_address == A_CTRL && i_writedata[0] |-> ##[1:3] o_shared_pin_transmit_oe)
        else $error("pin not driven");
    chk_rx_int_gate: assert property (
        o_cpu_int5 |-> $past(i_int_enable_serial)) else $error("int5 ungated");
    chk_tx_int_gate: assert property (
        o_cpu_int4 |-> o_shared_pin_transmit_oe && $past(i_int_enable_serial))
        else $error("int4 ungated");
    chk_tx_busy: assert property (
        wr_ok && i_address == A_DATA |-> ##[1:3] !o_cpu_int4) else $error("tx not full");
    chk_rx_clear: assert property (
        rd_ok && i_address == A_DATA |-> ##[1:3] !o_cpu_int5) else $error("rx not cleared");
    chk_status_ro: assert property (
        wr_ok && i_address == A_STAT |=> ($stable(o_cpu_int4) && $stable(o_cpu_int5))[*3])
        else $error("status written");
    // A bit lasts over 170 clocks even at the fastest rate, so a short glitch is caught.
    chk_bit_hold: assert property (
        $changed(o_shared_pin_transmit) |=> $stable(o_shared_pin_transmit)[*8])
        else $error("bit too short");
    cover property (wr_ok && i_address == A_DATA);
    cover property (o_cpu_int5);
    cover property (o_irq && rd_ok);
endmodule // uri_checker
bind uri_top uri_checker i_uri_checker (.i_clock(i_clock), .i_reset_n(i_reset_n),
    .i_address(i_address), .i_read(i_read), .i_write(i_write), .i_writedata(i_writedata),
    .i_byteenable(i_byteenable), .o_readdata(o_readdata), .o_waitrequest(o_waitrequest),
    .o_irq(o_irq), .i_int_enable_serial(i_int_enable_serial), .o_cpu_int4(o_cpu_int4),
    .o_cpu_int5(o_cpu_int5), .o_shared_pin_transmit(o_shared_pin_transmit),
    .o_shared_pin_transmit_oe(o_shared_pin_transmit_oe),
    .i_shared_pin_receive(i_shared_pin_receive));

//--- tb/uri_partner.sv
/*
 * Behavioural serial device on the far side of the transmit and receive pins.
 * Assumes the bench sets bit_ns to the rate programmed into the port.
 */
`timescale 1ns/1ns
module uri_partner (
    input wire i_line_in,   // Device transmit pin.
    input wire i_line_oe,   // High while the device drives it.
    output logic o_line_out // Device receive pin.
);
    real bit_ns = 8680.6;
    logic [7:0] got = 8'h00;
    logic stop_ok = 1'b0;
    // A released pin is pulled up, so it reads idle rather than a stale level.
    wire tx_level = i_line_oe ? i_line_in : 1'b1;
    initial o_line_out = 1'b1;
    // Sample each bit at its centre, LSB first, then the stop bit.
    always @(negedge tx_level) begin
        #(bit_ns * 1.5);
        for (int i = 0; i < 8; i++) begin
            got[i] = tx_level;
            #(bit_ns);
        end
        stop_ok = tx_level;
    end
    // Low start, eight data bits LSB first, high stop, then idle high.
    task automatic send(input logic [7:0] b);
        logic [9:0] f;
        f = {1'b1, b, 1'b0};
        for (int i = 0; i < 10; i++) begin
            o_line_out = f[i];
            #(bit_ns);
        end
    endtask
endmodule // uri_partner
